// ==== src/vbs_pkg.sv ====
package vbs_pkg;
    // -------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_SOFT_ERROR_COUNT = 8'hB3;
    localparam logic [7:0] ADDR_FILTER_COEFF_READBACK = 8'hB6;
    localparam logic [7:0] ADDR_SLICER_LEVEL_READBACK = 8'hB7;
    localparam logic [7:0] ADDR_FRAME_MASK_HIGH = 8'hB8;
    localparam logic [7:0] ADDR_FRAME_MASK_MID = 8'hB9;
    localparam logic [7:0] ADDR_FRAME_MASK_LOW = 8'hBA;
    localparam logic [7:0] ADDR_FRAME_REF_HIGH = 8'hBB;
    localparam logic [7:0] ADDR_FRAME_REF_MID = 8'hBC;
    localparam logic [7:0] ADDR_FRAME_REF_LOW = 8'hBD;
    localparam logic [7:0] ADDR_SERVICE_SELECT = 8'hC9;
    localparam logic [7:0] ADDR_BIT_ERROR_TOLERANCE = 8'hCE;
    localparam logic [7:0] ADDR_LINE_OUTPUT_MODE = 8'hCF;
    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [7:0] RST_MASK_BYTE = 8'h00;
    localparam logic [7:0] RST_REF_HIGH = 8'h27;
    localparam logic [7:0] RST_REF_MID = 8'h55;
    localparam logic [7:0] RST_REF_LOW = 8'h55;
    localparam logic [7:0] RST_SERVICE_SELECT = 8'h0D;
    localparam logic [7:0] RST_BIT_ERROR_TOLERANCE = 8'h15;
    localparam logic [7:0] RST_LINE_OUTPUT_MODE = 8'h6B;
    // -------------------------------------------------------------
    // field positions
    // -------------------------------------------------------------
    localparam int SVC_TTX_BIT = 0;
    localparam int SVC_NTSC_BIT = 1;
    localparam int SVC_FULL_BIT = 2;
    localparam int SVC_VPS_BIT = 3;
    localparam int SVC_WSS_BIT = 4;
    localparam int SVC_CC1_BIT = 5;
    localparam int SVC_CC2_BIT = 6;
    localparam int SVC_NOQUIT_BIT = 7;
    localparam int TOL_LOW_LSB = 0;
    localparam int TOL_MID_LSB = 2;
    localparam int TOL_HIGH_LSB = 4;
    localparam int OUT_CNT_MSB = 5;
    localparam int OUT_PAD_BIT = 6;
    localparam int OUT_DUMP_BIT = 7;
    // -------------------------------------------------------------
    // line numbers and counts
    // -------------------------------------------------------------
    localparam logic [9:0] LINE_VPS = 10'h010;
    localparam logic [9:0] LINE_CC = 10'h015;
    localparam logic [9:0] LINE_WSS = 10'h017;
    localparam logic [9:0] TTX_PAL_FIRST = 10'h006;
    localparam logic [9:0] TTX_PAL_LAST = 10'h016;
    localparam logic [9:0] TTX_NTSC_FIRST = 10'h00A;
    localparam logic [9:0] TTX_NTSC_LAST = 10'h014;
    localparam logic [6:0] PAD_TOTAL = 7'h40;
    localparam logic [7:0] FILL_BYTE = 8'h00;
    localparam logic [7:0] SOFT_MAX = 8'hFF;
    localparam logic [5:0] COEFF_FORBIDDEN = 6'h20;
    localparam logic [5:0] COEFF_MOST_NEG = 6'h21;
    // -------------------------------------------------------------
    // framer states
    // -------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_SEARCH = 5'h02,
        ST_ASSEMBLE = 5'h04,
        ST_PAD = 5'h08,
        ST_DONE = 5'h10
    } vbs_state_t;
endpackage : vbs_pkg

// ==== src/vbs_frame_match.sv ====
`timescale 1ns/1ps
module vbs_frame_match
    import vbs_pkg::*;
(
    input wire logic [23:0] i_window,
    input wire logic [23:0] i_ref,
    input wire logic [23:0] i_mask,
    input wire logic [7:0] i_tol,
    output logic o_match
);
    // -------------------------------------------------------------
    // error count per byte
    // -------------------------------------------------------------
    function automatic logic [3:0] vbs_errs(input logic [7:0] diff);
        logic [3:0] n;
        n = 4'h0;
        for (int k = 0; k < 8; k++) begin
            n = n + {3'h0, diff[k]};
        end
        return n;
    endfunction : vbs_errs

    logic [23:0] diff;
    logic [3:0] err_low;
    logic [3:0] err_mid;
    logic [3:0] err_high;

    assign diff = (i_window ^ i_ref) & ~i_mask;
    assign err_low = vbs_errs(diff[7:0]);
    assign err_mid = vbs_errs(diff[15:8]);
    assign err_high = vbs_errs(diff[23:16]);
    // reserved tolerance bits are never looked at
    assign o_match = (err_low <= {2'h0, i_tol[TOL_LOW_LSB +: 2]}) &&
                     (err_mid <= {2'h0, i_tol[TOL_MID_LSB +: 2]}) &&
                     (err_high <= {2'h0, i_tol[TOL_HIGH_LSB +: 2]});
endmodule : vbs_frame_match

// ==== src/vbs_line_gate.sv ====
`timescale 1ns/1ps
module vbs_line_gate
    import vbs_pkg::*;
(
    input wire logic [7:0] i_svc,
    input wire logic [9:0] i_line,
    input wire logic i_field2,
    output logic o_enable
);
    logic ttx_hit;
    logic vps_hit;
    logic wss_hit;
    logic cc_hit;

    // ntsc timing moves the teletext line range
    assign ttx_hit = i_svc[SVC_TTX_BIT] && (i_svc[SVC_NTSC_BIT] ?
        (i_line >= TTX_NTSC_FIRST && i_line <= TTX_NTSC_LAST) :
        (i_line >= TTX_PAL_FIRST && i_line <= TTX_PAL_LAST));
    assign vps_hit = i_svc[SVC_VPS_BIT] && (i_line == LINE_VPS);
    assign wss_hit = i_svc[SVC_WSS_BIT] && (i_line == LINE_WSS);
    assign cc_hit = (i_line == LINE_CC) &&
        ((i_svc[SVC_CC1_BIT] && !i_field2) || (i_svc[SVC_CC2_BIT] && i_field2));
    assign o_enable = i_svc[SVC_FULL_BIT] || ttx_hit || vps_hit || wss_hit || cc_hit;
endmodule : vbs_line_gate

// ==== src/vbs_byte_slicer.sv ====
`timescale 1ns/1ps
module vbs_byte_slicer
    import vbs_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RESETN,
    // register port
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [7:0] O_REG_RDATA,
    // bit slicer front end
    input wire logic I_SAMPLE_VALID,
    input wire logic [7:0] I_SAMPLE,
    input wire logic [5:0] I_COEFF,
    input wire logic [7:0] I_LEVEL,
    input wire logic I_SOFT_FIX,
    // line timing
    input wire logic I_LINE_START,
    input wire logic [9:0] I_LINE_NUM,
    input wire logic I_FIELD2,
    input wire logic I_RUNIN_WIN,
    // service controls
    output logic O_NTSC_MODE,
    output logic O_HQUIT_EN,
    // byte output
    output logic O_BYTE_VALID,
    output logic [7:0] O_BYTE,
    output logic O_BYTE_FRAMED,
    output logic O_LINE_DONE
);
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [7:0] vbs_abs(input logic [7:0] s);
        logic [7:0] a;
        a = s[7] ? (~s + 8'h01) : s;
        return a;
    endfunction : vbs_abs

    function automatic logic vbs_hit(input logic [7:0] a, input logic [7:0] w);
        return I_REG_WR && (I_REG_ADDR == a) && (w == a);
    endfunction : vbs_hit

    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    logic [7:0] mask_high_q;
    logic [7:0] mask_mid_q;
    logic [7:0] mask_low_q;
    logic [7:0] ref_high_q;
    logic [7:0] ref_mid_q;
    logic [7:0] ref_low_q;
    logic [7:0] svc_q;
    logic [7:0] tol_q;
    logic [7:0] mode_q;
    logic [7:0] soft_q;
    logic [7:0] soft_d;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic [5:0] coeff_safe;
    logic [23:0] shift_q;
    logic [23:0] ref_word;
    logic [23:0] mask_word;
    logic frame_ok;
    logic line_en;
    logic line_en_q;
    logic dump_q;
    logic framed_q;
    logic new_bit;
    logic bit_strobe;
    logic [2:0] bit_cnt_q;
    logic [7:0] asm_q;
    logic [6:0] emitted_q;
    logic [5:0] want_cnt;
    logic win_q;
    logic win_fall;
    vbs_state_t state_q;
    vbs_state_t state_d;
    logic start_asm;
    logic asm_byte;
    logic byte_valid_q;
    logic [7:0] byte_q;
    logic byte_framed_q;
    logic line_done_q;

    // -------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ref_high_q <= RST_REF_HIGH;
            ref_mid_q <= RST_REF_MID;
            ref_low_q <= RST_REF_LOW;
        end else begin
            if (vbs_hit(I_REG_ADDR, ADDR_FRAME_REF_HIGH)) begin
                ref_high_q <= I_REG_WDATA;
            end
            if (vbs_hit(I_REG_ADDR, ADDR_FRAME_REF_MID)) begin
                ref_mid_q <= I_REG_WDATA;
            end
            if (vbs_hit(I_REG_ADDR, ADDR_FRAME_REF_LOW)) begin
                ref_low_q <= I_REG_WDATA;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            mask_high_q <= RST_MASK_BYTE;
            mask_mid_q <= RST_MASK_BYTE;
            mask_low_q <= RST_MASK_BYTE;
        end else begin
            if (vbs_hit(I_REG_ADDR, ADDR_FRAME_MASK_HIGH)) begin
                mask_high_q <= I_REG_WDATA;
            end
            if (vbs_hit(I_REG_ADDR, ADDR_FRAME_MASK_MID)) begin
                mask_mid_q <= I_REG_WDATA;
            end
            if (vbs_hit(I_REG_ADDR, ADDR_FRAME_MASK_LOW)) begin
                mask_low_q <= I_REG_WDATA;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            svc_q <= RST_SERVICE_SELECT;
            tol_q <= RST_BIT_ERROR_TOLERANCE;
            mode_q <= RST_LINE_OUTPUT_MODE;
        end else begin
            if (vbs_hit(I_REG_ADDR, ADDR_SERVICE_SELECT)) begin
                svc_q <= I_REG_WDATA;
            end
            // upper bits are stored but unused, host keeps them zero
            if (vbs_hit(I_REG_ADDR, ADDR_BIT_ERROR_TOLERANCE)) begin
                tol_q <= I_REG_WDATA;
            end
            if (vbs_hit(I_REG_ADDR, ADDR_LINE_OUTPUT_MODE)) begin
                mode_q <= I_REG_WDATA;
            end
        end
    end

    assign O_NTSC_MODE = svc_q[SVC_NTSC_BIT];
    assign O_HQUIT_EN = !svc_q[SVC_NOQUIT_BIT];

    // -------------------------------------------------------------
    // soft error counter
    // -------------------------------------------------------------
    // a repair in the read cycle counts into the fresh value, never lost
    always_comb begin
        soft_d = soft_q;
        if (I_REG_RD && I_REG_ADDR == ADDR_SOFT_ERROR_COUNT) begin
            soft_d = 8'h00;
        end
        if (I_SOFT_FIX && soft_d != SOFT_MAX) begin
            soft_d = soft_d + 8'h01;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            soft_q <= 8'h00;
        end else begin
            soft_q <= soft_d;
        end
    end

    // -------------------------------------------------------------
    // read path
    // -------------------------------------------------------------
    // the forbidden code is shown as the most negative legal one
    assign coeff_safe = (I_COEFF == COEFF_FORBIDDEN) ? COEFF_MOST_NEG : I_COEFF;

    always_comb begin
        rdata_d = 8'h00;
        case (I_REG_ADDR)
            ADDR_SOFT_ERROR_COUNT: begin
                rdata_d = soft_q;
            end
            ADDR_FILTER_COEFF_READBACK: begin
                rdata_d = {{2{coeff_safe[5]}}, coeff_safe};
            end
            ADDR_SLICER_LEVEL_READBACK: begin
                rdata_d = I_LEVEL;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rdata_q <= 8'h00;
        end else if (I_REG_RD) begin
            rdata_q <= rdata_d;
        end
    end

    assign O_REG_RDATA = rdata_q;

    // -------------------------------------------------------------
    // slicing and framing search
    // -------------------------------------------------------------
    assign new_bit = vbs_abs(I_SAMPLE) > I_LEVEL;
    assign bit_strobe = I_SAMPLE_VALID;
    assign ref_word = {ref_high_q, ref_mid_q, ref_low_q};
    assign mask_word = {mask_high_q, mask_mid_q, mask_low_q};

    // oldest bit ends up at bit 0 after 24 shifts
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            shift_q <= 24'h000000;
        end else if (I_LINE_START) begin
            shift_q <= 24'h000000;
        end else if (bit_strobe) begin
            shift_q <= {new_bit, shift_q[23:1]};
        end
    end

    vbs_frame_match u_match (
        .i_window(shift_q),
        .i_ref(ref_word),
        .i_mask(mask_word),
        .i_tol(tol_q),
        .o_match(frame_ok)
    );

    vbs_line_gate u_gate (
        .i_svc(svc_q),
        .i_line(I_LINE_NUM),
        .i_field2(I_FIELD2),
        .o_enable(line_en)
    );

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            win_q <= 1'b0;
            line_en_q <= 1'b0;
            dump_q <= 1'b0;
        end else begin
            win_q <= I_RUNIN_WIN;
            if (I_LINE_START) begin
                line_en_q <= line_en;
                dump_q <= mode_q[OUT_DUMP_BIT];
            end
        end
    end

    assign win_fall = win_q && !I_RUNIN_WIN;
    // byte count of zero is read as one so the framing byte still goes out
    assign want_cnt = (mode_q[OUT_CNT_MSB:0] == 6'h00) ? 6'h01 : mode_q[OUT_CNT_MSB:0];

    // -------------------------------------------------------------
    // framer state machine
    // -------------------------------------------------------------
    assign start_asm = (state_q == ST_SEARCH) && I_RUNIN_WIN && frame_ok && line_en_q;
    assign asm_byte = (state_q == ST_ASSEMBLE) && bit_strobe && (bit_cnt_q == 3'h7);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                state_d = ST_IDLE;
            end
            ST_SEARCH: begin
                if (start_asm) begin
                    state_d = (want_cnt != 6'h01) ? ST_ASSEMBLE :
                        (mode_q[OUT_PAD_BIT] ? ST_PAD : ST_DONE);
                end else if (win_fall) begin
                    // dump mode outputs raw bytes of lines without a code
                    state_d = dump_q ? ST_ASSEMBLE : ST_DONE;
                end
            end
            ST_ASSEMBLE: begin
                if (asm_byte && emitted_q + 7'h01 >= {1'b0, want_cnt}) begin
                    state_d = mode_q[OUT_PAD_BIT] ? ST_PAD : ST_DONE;
                end
            end
            ST_PAD: begin
                if (emitted_q + 7'h01 >= PAD_TOTAL) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                state_d = ST_DONE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (I_LINE_START) begin
            state_d = (line_en || mode_q[OUT_DUMP_BIT]) ? ST_SEARCH : ST_IDLE;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // -------------------------------------------------------------
    // byte assembly
    // -------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            bit_cnt_q <= 3'h0;
            asm_q <= 8'h00;
            framed_q <= 1'b0;
        end else if (I_LINE_START) begin
            bit_cnt_q <= 3'h0;
            framed_q <= 1'b0;
        end else if (start_asm) begin
            bit_cnt_q <= 3'h0;
            framed_q <= 1'b1;
        end else if (state_q == ST_ASSEMBLE && bit_strobe) begin
            asm_q <= {new_bit, asm_q[7:1]};
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // the framing byte counts as the first output byte of a framed line
    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            emitted_q <= 7'h00;
        end else if (I_LINE_START) begin
            emitted_q <= 7'h00;
        end else if (start_asm || asm_byte || state_q == ST_PAD) begin
            emitted_q <= emitted_q + 7'h01;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            byte_valid_q <= 1'b0;
            byte_q <= 8'h00;
            byte_framed_q <= 1'b0;
        end else begin
            byte_valid_q <= 1'b0;
            if (start_asm) begin
                byte_valid_q <= 1'b1;
                byte_q <= shift_q[23:16];
                byte_framed_q <= 1'b1;
            end else if (asm_byte) begin
                byte_valid_q <= 1'b1;
                byte_q <= {new_bit, asm_q[7:1]};
                byte_framed_q <= framed_q;
            end else if (state_q == ST_PAD) begin
                byte_valid_q <= 1'b1;
                byte_q <= FILL_BYTE;
                byte_framed_q <= framed_q;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            line_done_q <= 1'b0;
        end else begin
            line_done_q <= (state_q != ST_DONE) && (state_d == ST_DONE) && !I_LINE_START;
        end
    end

    assign O_BYTE_VALID = byte_valid_q;
    assign O_BYTE = byte_q;
    assign O_BYTE_FRAMED = byte_framed_q;
    assign O_LINE_DONE = line_done_q;
endmodule : vbs_byte_slicer

// ==== test/vbs_byte_slicer_monitor.sv ====
`timescale 1ns/1ps
// ------------------------------
// port checker
// ------------------------------
module vbs_slicer_chk (
    input wire logic I_CLK_SYS,
    input wire logic I_RESETN,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [7:0] O_REG_RDATA,
    input wire logic [5:0] I_COEFF,
    input wire logic [7:0] I_LEVEL,
    input wire logic O_NTSC_MODE,
    input wire logic O_HQUIT_EN,
    input wire logic O_LINE_DONE
);
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RESETN);
    logic svc_wr;
    logic rd_cf;
    logic rd_wo;
    assign svc_wr = I_REG_WR && (I_REG_ADDR == 8'hC9);
    assign rd_cf = I_REG_RD && (I_REG_ADDR == 8'hB6);
    // control set is write-only, so reads must not leak it
    assign rd_wo = I_REG_RD && (I_REG_ADDR inside {[8'hB8:8'hBD], 8'hC9, 8'hCE, 8'hCF});
    quit_follow_a: assert property (
        svc_wr |=> O_HQUIT_EN == !$past(I_REG_WDATA[7])) else $error("bad quit enable");
    ntsc_follow_a: assert property (
        svc_wr |=> O_NTSC_MODE == $past(I_REG_WDATA[1])) else $error("bad ntsc mode");
    coeff_sext_a: assert property (
        rd_cf && I_COEFF != 6'h20 |=> O_REG_RDATA == {{2{$past(I_COEFF[5])}}, $past(I_COEFF)})
        else $error("bad coeff readback");
    coeff_forbid_a: assert property (
        rd_cf && I_COEFF == 6'h20 |=> O_REG_RDATA == 8'hE1) else $error("bad coeff clamp");
    level_read_a: assert property (
        I_REG_RD && I_REG_ADDR == 8'hB7 |=> O_REG_RDATA == $past(I_LEVEL))
        else $error("bad level readback");
    wo_zero_a: assert property (
        rd_wo |=> O_REG_RDATA == 8'h00) else $error("write-only place read nonzero");
    rdata_hold_a: assert property (
        !I_REG_RD |=> $stable(O_REG_RDATA)) else $error("read data moved");
    done_pulse_a: assert property (
        O_LINE_DONE |=> !O_LINE_DONE) else $error("line done too long");
endmodule : vbs_slicer_chk

bind vbs_byte_slicer vbs_slicer_chk i_chk (.I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN),
    .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR),
    .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA), .I_COEFF(I_COEFF), .I_LEVEL(I_LEVEL),
    .O_NTSC_MODE(O_NTSC_MODE), .O_HQUIT_EN(O_HQUIT_EN), .O_LINE_DONE(O_LINE_DONE));

// ==== test/vbs_video_src.sv ====
`timescale 1ns/1ps
// ------------------------------
// video line source
// ------------------------------
module vbs_video_src (
    input wire logic i_clk,
    output logic o_line_start,
    output logic [9:0] o_line_num,
    output logic o_field2,
    output logic o_runin_win,
    output logic o_sample_valid,
    output logic [7:0] o_sample
);
    initial begin
        o_line_start = 1'b0;
        o_line_num = 10'h000;
        o_field2 = 1'b0;
        o_runin_win = 1'b0;
        o_sample_valid = 1'b0;
        o_sample = 8'h00;
    end
    task automatic start_line(input logic [9:0] num, input logic f2);
        @(posedge i_clk);
        #1;
        o_line_num = num;
        o_field2 = f2;
        o_line_start = 1'b1;
        o_runin_win = 1'b1;
        @(posedge i_clk);
        #1;
        o_line_start = 1'b0;
    endtask : start_line
    task automatic end_window;
        o_runin_win = 1'b0;
    endtask : end_window
    // ones go out negative so only the magnitude slices them
    task automatic send_bits(input logic [23:0] bits, input int n);
        for (int i = 0; i < n; i++) begin
            o_sample = bits[i] ? 8'h90 : 8'h30;
            o_sample_valid = 1'b1;
            @(posedge i_clk);
            #1;
            o_sample_valid = 1'b0;
            o_sample = ~o_sample;
            @(posedge i_clk);
            #1;
        end
    endtask : send_bits
endmodule : vbs_video_src

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench
    import vbs_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fix = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic [7:0] level = 8'h40;
    logic [5:0] coeff = 6'h00;
    logic [7:0] rdat, bbyte, smp;
    logic [9:0] lnum;
    logic lst, f2, win, sv, ntsc, hquit, bval, bfr, ldone;
    logic [8:0] got[$];
    int done_cnt = 0;
    int fails = 0;
    int samples_checked = 0;
    always #50 clk = ~clk;
    vbs_video_src i_src (.i_clk(clk), .o_line_start(lst), .o_line_num(lnum), .o_field2(f2),
        .o_runin_win(win), .o_sample_valid(sv), .o_sample(smp));
    vbs_byte_slicer i_dut (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdat), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdat),
        .I_SAMPLE_VALID(sv), .I_SAMPLE(smp), .I_COEFF(coeff), .I_LEVEL(level),
        .I_SOFT_FIX(fix), .I_LINE_START(lst), .I_LINE_NUM(lnum), .I_FIELD2(f2),
        .I_RUNIN_WIN(win), .O_NTSC_MODE(ntsc), .O_HQUIT_EN(hquit), .O_BYTE_VALID(bval),
        .O_BYTE(bbyte), .O_BYTE_FRAMED(bfr), .O_LINE_DONE(ldone));
    always @(posedge clk) begin
        if (bval) got.push_back({bfr, bbyte});
        if (ldone) done_cnt++;
    end
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    task automatic reg_io(input logic w, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] q);
        @(posedge clk);
        #1;
        addr = a;
        wdat = d;
        wr = w;
        rd = !w;
        @(posedge clk);
        #1;
        wr = 1'b0;
        rd = 1'b0;
        q = rdat;
    endtask : reg_io
    task automatic wait_done(input int n0);
        for (int i = 0; i < 400 && done_cnt == n0; i++) @(posedge clk);
        #1;
        check({8'h00, done_cnt != n0}, 9'h001);
    endtask : wait_done
    task automatic t_readback;
        logic [7:0] d;
        reg_io(1'b0, ADDR_FILTER_COEFF_READBACK, 8'h00, d);
        check({1'b0, d}, 9'h000);
        coeff = 6'h21;
        reg_io(1'b0, ADDR_FILTER_COEFF_READBACK, 8'h00, d);
        check({1'b0, d}, 9'h0E1);
        coeff = 6'h20;
        level = 8'h5A;
        reg_io(1'b0, ADDR_FILTER_COEFF_READBACK, 8'h00, d);
        check({1'b0, d}, 9'h0E1);
        reg_io(1'b0, ADDR_SLICER_LEVEL_READBACK, 8'h00, d);
        check({1'b0, d}, 9'h05A);
        level = 8'h40;
        reg_io(1'b0, 8'hA0, 8'h00, d);
        check({1'b0, d}, 9'h000);
        reg_io(1'b0, ADDR_FRAME_MASK_HIGH, 8'h00, d);
        check({1'b0, d}, 9'h000);
        $display("readback test done");
    endtask : t_readback
    task automatic t_soft;
        logic [7:0] d;
        fix = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        fix = 1'b0;
        reg_io(1'b0, ADDR_SOFT_ERROR_COUNT, 8'h00, d);
        check({1'b0, d}, 9'h003);
        reg_io(1'b0, ADDR_SOFT_ERROR_COUNT, 8'h00, d);
        check({1'b0, d}, 9'h000);
        fix = 1'b1;
        repeat (260) @(posedge clk);
        #1;
        fix = 1'b0;
        reg_io(1'b0, ADDR_SOFT_ERROR_COUNT, 8'h00, d);
        check({1'b0, d}, 9'h0FF);
        $display("soft counter test done");
    endtask : t_soft
    task automatic t_frame;
        logic [7:0] d;
        logic [7:0] flt;
        int n0;
        flt = 8'h00;
        reg_io(1'b1, ADDR_LINE_OUTPUT_MODE, 8'h43, d);
        got.delete();
        n0 = done_cnt;
        i_src.start_line(10'h064, 1'b0);
        i_src.send_bits(24'h275554, 24);
        i_src.end_window();
        i_src.send_bits(24'h003CA5, 16);
        wait_done(n0);
        foreach (got[i]) if (i > 2) flt = flt | got[i][7:0];
        check({8'h00, got.size() == 64}, 9'h001);
        check(got[0], 9'h127);
        check(got[1], 9'h1A5);
        check(got[2], 9'h13C);
        check({1'b0, flt}, 9'h000);
        $display("framed line test done");
    endtask : t_frame
    task automatic t_nomatch;
        logic [7:0] d;
        int n0;
        reg_io(1'b1, ADDR_SERVICE_SELECT, 8'h22, d);
        reg_io(1'b1, ADDR_BIT_ERROR_TOLERANCE, 8'h14, d);
        got.delete();
        n0 = done_cnt;
        i_src.start_line(10'h015, 1'b0);
        i_src.send_bits(24'h275554, 24);
        i_src.end_window();
        wait_done(n0);
        check({8'h00, got.size() == 0}, 9'h001);
        $display("tolerance reject test done");
    endtask : t_nomatch
    task automatic t_dump;
        logic [7:0] d;
        int n0;
        reg_io(1'b1, ADDR_SERVICE_SELECT, 8'hA0, d);
        reg_io(1'b1, ADDR_LINE_OUTPUT_MODE, 8'h81, d);
        got.delete();
        n0 = done_cnt;
        i_src.start_line(10'h015, 1'b1);
        i_src.send_bits(24'h275555, 24);
        i_src.end_window();
        // assembly of a dump line starts one edge after the window falls
        @(posedge clk);
        #1;
        i_src.send_bits(24'h0000C3, 8);
        wait_done(n0);
        check({8'h00, got.size() == 1}, 9'h001);
        check(got[0], 9'h0C3);
        $display("dump line test done");
    endtask : t_dump
    task automatic t_gate;
        logic [7:0] d;
        int n0;
        reg_io(1'b1, ADDR_SERVICE_SELECT, 8'h18, d);
        reg_io(1'b1, ADDR_LINE_OUTPUT_MODE, 8'h01, d);
        got.delete();
        n0 = done_cnt;
        i_src.start_line(10'h017, 1'b0);
        i_src.send_bits(24'h275555, 24);
        i_src.end_window();
        wait_done(n0);
        check({8'h00, got.size() == 1}, 9'h001);
        check(got[0], 9'h127);
        $display("single byte line test done");
    endtask : t_gate
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check({7'h00, hquit, ntsc}, 9'h002);
        t_readback;
        t_soft;
        t_frame;
        t_nomatch;
        t_dump;
        t_gate;
        complete_run;
    end
    initial begin
        #3000000;
        fails++;
        complete_run;
    end
endmodule : testbench
